// ===== pkg/rlc_consts.vh
// register offsets, field positions, reset values and widths of the reference ladder control
`ifndef RLC_CONSTS_VH
`define RLC_CONSTS_VH

// register addresses on the plain register port
`define RLC_ADDR_W          4
`define RLC_OFS_CONTROL_A   4'h0
`define RLC_OFS_LEVEL       4'h1

// control register a field positions
`define RLC_BIT_ENABLE      7
`define RLC_BIT_PIN_A_OE    5
`define RLC_BIT_PIN_B_OE    4
`define RLC_BIT_HSS_HI      3
`define RLC_BIT_HSS_LO      2
`define RLC_BIT_LSS         0

// writable masks, unimplemented bits are zero
`define RLC_MASK_CONTROL_A  8'hbd
`define RLC_MASK_LEVEL      8'h1f

// reset values
`define RLC_RST_CONTROL_A   8'h00
`define RLC_RST_LEVEL       8'h00

// tap code width and tap count
`define RLC_TAP_W           5
`define RLC_TAP_COUNT       32

// high source select codes
`define RLC_HSS_SUPPLY      2'h0
`define RLC_HSS_EXT_PIN     2'h1
`define RLC_HSS_FIXED_REF   2'h2
`define RLC_HSS_RESERVED    2'h3

`endif

// ===== hdl/rlc_tap_decode.v
// one-hot decoder that picks a single ladder tap from the level code
`timescale 1ns/100ps
`include "rlc_consts.vh"

module rlc_tap_decode #(
    parameter TAP_W = `RLC_TAP_W,
    parameter TAPS  = `RLC_TAP_COUNT
) (
    // level code and gate
    input  wire [TAP_W-1:0] code,
    input  wire             enable,
    // one-hot tap switches
    output reg  [TAPS-1:0]  taps
);

    integer i;

    // no tap closes while disabled so the ladder draws nothing
    always @* begin
        taps = {TAPS{1'b0}};
        for (i = 0; i < TAPS; i = i + 1) begin
            if (enable && (code == i[TAP_W-1:0])) begin
                taps[i] = 1'b1;
            end
        end
    end

endmodule // rlc_tap_decode

// ===== hdl/rlc_pin_override.v
// override of one pad when it carries the ladder level
`timescale 1ns/100ps
`include "rlc_consts.vh"

module rlc_pin_override (
    // selection
    input  wire level_sel,
    // digital pad side
    input  wire pad_in,
    input  wire dig_out,
    input  wire dig_oe_b,
    input  wire dig_pullup_en,
    input  wire dig_ccd_en,
    // pad controls after override
    output wire pad_out,
    output wire pad_oe_b,
    output wire pad_in_en,
    output wire pad_pullup_en,
    output wire pad_ccd_en,
    output wire pad_analog_sw,
    output wire pad_rd
);

    // analog use: buffer off, detector off, pull-up and current drive off
    assign pad_out       = level_sel ? 1'b0 : dig_out;        // RL4
    assign pad_oe_b      = level_sel ? 1'b1 : dig_oe_b;       // RL4
    assign pad_in_en     = ~level_sel;                        // RL4
    assign pad_pullup_en = level_sel ? 1'b0 : dig_pullup_en;  // RL4
    assign pad_ccd_en    = level_sel ? 1'b0 : dig_ccd_en;     // RL4
    assign pad_analog_sw = level_sel;                         // RL3
    // reads return zero whatever the pad voltage
    assign pad_rd        = level_sel ? 1'b0 : pad_in;         // RL5

endmodule // rlc_pin_override

// ===== hdl/rlc_ref_ladder_ctrl.v
// register file and control of the 5-bit reference ladder converter
`timescale 1ns/100ps
`include "rlc_consts.vh"

// Behaviour
// RL1: ladder is powered and operated only while enable bit 7 of control a is set.
// RL2: low five bits of level register pick one of 32 taps.
// RL3: bits 5 and 4 of control a connect level to pin a and pin b.
// RL4: a level pin has buffer, detector, pull-up and current drive overridden off.
// RL5: a digital read of a level pin returns zero.
// RL6: bits 3:2 pick supply, external pin or fixed reference; code 11 reserved.
// RL7: bit 0 ties ladder low end to ground or external negative pin.
// RL8: converter keeps running in sleep; wake leaves control a unchanged.
// RL9: reset disables converter, disconnects both pins and clears level code.
// RL10: unimplemented bits read zero and ignore writes.
// RL11: writes take effect next edge; ladder controls are static registered lines.
module rlc_ref_ladder_ctrl #(
    parameter TAP_W = `RLC_TAP_W,
    parameter TAPS  = `RLC_TAP_COUNT
) (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   rst_b,
    // register port
    input  wire [`RLC_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    // power state, accepted but has no effect on the converter
    input  wire                   sleep_active,
    // analog ladder controls
    output wire                   ladder_power_en,
    output wire [TAPS-1:0]        ladder_tap_sel,
    output wire                   high_src_supply,
    output wire                   high_src_ext_pin,
    output wire                   high_src_fixed_ref,
    output wire                   low_src_ground,
    output wire                   low_src_ext_pin,
    // pad a digital side
    input  wire                   pad_a_in,
    input  wire                   pad_a_dig_out,
    input  wire                   pad_a_dig_oe_b,
    input  wire                   pad_a_dig_pullup_en,
    input  wire                   pad_a_dig_ccd_en,
    // pad a controls
    output wire                   pad_a_out,
    output wire                   pad_a_oe_b,
    output wire                   pad_a_in_en,
    output wire                   pad_a_pullup_en,
    output wire                   pad_a_ccd_en,
    output wire                   level_pin_a,
    output wire                   pad_a_rd,
    // pad b digital side
    input  wire                   pad_b_in,
    input  wire                   pad_b_dig_out,
    input  wire                   pad_b_dig_oe_b,
    input  wire                   pad_b_dig_pullup_en,
    input  wire                   pad_b_dig_ccd_en,
    // pad b controls
    output wire                   pad_b_out,
    output wire                   pad_b_oe_b,
    output wire                   pad_b_in_en,
    output wire                   pad_b_pullup_en,
    output wire                   pad_b_ccd_en,
    output wire                   level_pin_b,
    output wire                   pad_b_rd
);

    reg  [7:0] control_a_q;
    reg  [7:0] control_a_d;
    reg  [7:0] level_q;
    reg  [7:0] level_d;
    wire       ladder_enable;
    wire       pin_a_level_out_en;
    wire       pin_b_level_out_en;
    wire [1:0] high_source_select;
    wire       low_source_select;
    wire [TAP_W-1:0] tap_code;
    wire [TAPS-1:0]  tap_sel_d;
    reg  [TAPS-1:0]  tap_sel_q;
    reg              ladder_power_q;
    reg              high_supply_d;
    reg              high_supply_q;
    reg              high_ext_pin_d;
    reg              high_ext_pin_q;
    reg              high_fixed_ref_d;
    reg              high_fixed_ref_q;
    reg              low_ground_d;
    reg              low_ground_q;
    reg              low_ext_pin_d;
    reg              low_ext_pin_q;
    reg              pin_a_sel_q;
    reg              pin_b_sel_q;
    reg  [7:0]       rdata_d;

    // write decode; masks keep unimplemented bits at zero
    always @* begin
        control_a_d = control_a_q;
        level_d     = level_q;
        if (reg_wr && (reg_addr == `RLC_OFS_CONTROL_A)) begin
            control_a_d = reg_wdata & `RLC_MASK_CONTROL_A; // RL10
        end else if (reg_wr && (reg_addr == `RLC_OFS_LEVEL)) begin
            level_d = reg_wdata & `RLC_MASK_LEVEL; // RL10
        end
    end

    // sleep_active is left out of every process so nothing stops in sleep
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_a_q <= `RLC_RST_CONTROL_A; // RL9
            level_q     <= `RLC_RST_LEVEL; // RL9
        end else begin
            control_a_q <= control_a_d; // RL11 RL8
            level_q     <= level_d; // RL11
        end
    end

    // read mux; unmapped addresses and idle cycles give zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `RLC_OFS_CONTROL_A) begin
                rdata_d = control_a_q; // RL10
            end else if (reg_addr == `RLC_OFS_LEVEL) begin
                rdata_d = level_q; // RL10
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // fields of the values the coming edge stores, so the switch flops stay in step with the registers
    assign ladder_enable      = control_a_d[`RLC_BIT_ENABLE];
    assign pin_a_level_out_en = control_a_d[`RLC_BIT_PIN_A_OE];
    assign pin_b_level_out_en = control_a_d[`RLC_BIT_PIN_B_OE];
    assign high_source_select = control_a_d[`RLC_BIT_HSS_HI:`RLC_BIT_HSS_LO];
    assign low_source_select  = control_a_d[`RLC_BIT_LSS];
    assign tap_code           = level_d[TAP_W-1:0];

    // tap decode of the next level code; gated by enable so a disabled ladder draws nothing
    rlc_tap_decode #(
        .TAP_W (TAP_W),
        .TAPS  (TAPS)
    ) u_tap_decode (
        .code   (tap_code),
        .enable (ladder_enable),
        .taps   (tap_sel_d)
    ); // RL2

    // source decode; reserved code closes no high switch, avoiding shorts between sources
    always @* begin
        high_supply_d    = 1'b0;
        high_ext_pin_d   = 1'b0;
        high_fixed_ref_d = 1'b0;
        low_ground_d     = 1'b0;
        low_ext_pin_d    = 1'b0;
        if (ladder_enable) begin
            case (high_source_select)
                `RLC_HSS_SUPPLY: begin
                    high_supply_d = 1'b1; // RL6
                end
                `RLC_HSS_EXT_PIN: begin
                    high_ext_pin_d = 1'b1; // RL6
                end
                `RLC_HSS_FIXED_REF: begin
                    high_fixed_ref_d = 1'b1; // RL6
                end
                default: begin
                    high_supply_d = 1'b0; // RL6
                end
            endcase
            if (low_source_select) begin
                low_ext_pin_d = 1'b1; // RL7
            end else begin
                low_ground_d = 1'b1; // RL7
            end
        end
    end

    // ladder power and tap switches; flops keep decode glitches from closing two taps at once
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ladder_power_q <= 1'b0; // RL9
            tap_sel_q      <= {TAPS{1'b0}}; // RL9
        end else begin
            ladder_power_q <= ladder_enable; // RL1 RL11
            tap_sel_q      <= tap_sel_d; // RL2 RL11
        end
    end

    // source switches, updated on the same edge as control a
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_supply_q    <= 1'b0; // RL9
            high_ext_pin_q   <= 1'b0; // RL9
            high_fixed_ref_q <= 1'b0; // RL9
            low_ground_q     <= 1'b0; // RL9
            low_ext_pin_q    <= 1'b0; // RL9
        end else begin
            high_supply_q    <= high_supply_d; // RL6 RL11
            high_ext_pin_q   <= high_ext_pin_d; // RL6 RL11
            high_fixed_ref_q <= high_fixed_ref_d; // RL6 RL11
            low_ground_q     <= low_ground_d; // RL7 RL11
            low_ext_pin_q    <= low_ext_pin_d; // RL7 RL11
        end
    end

    // pin routing; independent of enable so a pin can be parked before the ladder starts
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_a_sel_q <= 1'b0; // RL9
            pin_b_sel_q <= 1'b0; // RL9
        end else begin
            pin_a_sel_q <= pin_a_level_out_en; // RL3 RL11
            pin_b_sel_q <= pin_b_level_out_en; // RL3 RL11
        end
    end

    // the analog side sees only flop outputs
    assign ladder_power_en    = ladder_power_q; // RL1
    assign ladder_tap_sel     = tap_sel_q; // RL2
    assign high_src_supply    = high_supply_q; // RL6
    assign high_src_ext_pin   = high_ext_pin_q; // RL6
    assign high_src_fixed_ref = high_fixed_ref_q; // RL6
    assign low_src_ground     = low_ground_q; // RL7
    assign low_src_ext_pin    = low_ext_pin_q; // RL7

    // pad a override, independent of pad b
    rlc_pin_override u_pin_a (
        .level_sel     (pin_a_sel_q),
        .pad_in        (pad_a_in),
        .dig_out       (pad_a_dig_out),
        .dig_oe_b      (pad_a_dig_oe_b),
        .dig_pullup_en (pad_a_dig_pullup_en),
        .dig_ccd_en    (pad_a_dig_ccd_en),
        .pad_out       (pad_a_out),
        .pad_oe_b      (pad_a_oe_b),
        .pad_in_en     (pad_a_in_en),
        .pad_pullup_en (pad_a_pullup_en),
        .pad_ccd_en    (pad_a_ccd_en),
        .pad_analog_sw (level_pin_a),
        .pad_rd        (pad_a_rd)
    ); // RL3 RL4 RL5

    // pad b override
    rlc_pin_override u_pin_b (
        .level_sel     (pin_b_sel_q),
        .pad_in        (pad_b_in),
        .dig_out       (pad_b_dig_out),
        .dig_oe_b      (pad_b_dig_oe_b),
        .dig_pullup_en (pad_b_dig_pullup_en),
        .dig_ccd_en    (pad_b_dig_ccd_en),
        .pad_out       (pad_b_out),
        .pad_oe_b      (pad_b_oe_b),
        .pad_in_en     (pad_b_in_en),
        .pad_pullup_en (pad_b_pullup_en),
        .pad_ccd_en    (pad_b_ccd_en),
        .pad_analog_sw (level_pin_b),
        .pad_rd        (pad_b_rd)
    ); // RL3 RL4 RL5

endmodule // rlc_ref_ladder_ctrl

// ===== testbench/rlc_checker.sv
// assertion checker on the reference ladder control ports
`timescale 1ns/100ps
module rlc_checker #(parameter TAPS = 32) (
    // clock, reset, register port
    input wire ref_clk, rst_b, reg_wr, reg_rd, sleep_active,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata, reg_rdata,
    // ladder and pad controls
    input wire ladder_power_en, high_src_supply, high_src_ext_pin, high_src_fixed_ref,
    input wire low_src_ground, low_src_ext_pin, level_pin_a, level_pin_b, pad_a_rd, pad_b_rd,
    input wire pad_a_oe_b, pad_a_in_en, pad_a_pullup_en, pad_a_ccd_en,
    input wire [TAPS-1:0] ladder_tap_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // write to control a
    wire w0 = reg_wr && reg_addr == 4'h0;

    a_enable_bit: assert property (w0 |=> ladder_power_en == $past(reg_wdata[7])) else $error("enable");
    a_tap_gated: assert property (!ladder_power_en |-> ladder_tap_sel == '0) else $error("tap off");
    a_tap_pick: assert property (reg_wr && reg_addr == 4'h1 && ladder_power_en
        |=> ladder_tap_sel == (1 << $past(reg_wdata[4:0]))) else $error("tap");
    a_pin_route: assert property (w0 |=> {level_pin_a, level_pin_b} == $past(reg_wdata[5:4])) else $error("pin");
    a_pad_override: assert property (level_pin_a |-> pad_a_oe_b && !pad_a_in_en
        && !pad_a_pullup_en && !pad_a_ccd_en) else $error("pad");
    a_level_read: assert property (!(level_pin_a && pad_a_rd) && !(level_pin_b && pad_b_rd)) else $error("rd");
    a_high_src: assert property (w0 |=> {high_src_fixed_ref, high_src_ext_pin, high_src_supply}
        == ($past(reg_wdata[7]) ? 3'h1 << $past(reg_wdata[3:2]) : 3'h0)) else $error("high");
    a_low_src: assert property (w0 |=> {low_src_ext_pin, low_src_ground}
        == ($past(reg_wdata[7]) ? ($past(reg_wdata[0]) ? 2'h2 : 2'h1) : 2'h0)) else $error("low");
    a_sleep_hold: assert property (sleep_active && !reg_wr |=> $stable({ladder_power_en, level_pin_a}))
        else $error("sleep");
    a_reset_clear: assert property (disable iff (1'b0) !rst_b |-> !ladder_power_en && !level_pin_a
        && !level_pin_b) else $error("reset");
    a_unimpl_zero: assert property (reg_rd |=> (reg_rdata & ($past(reg_addr) == 4'h0 ? 8'h42 : 8'he0))
        == 8'h00) else $error("unimpl");
    // main scenarios
    cover property (w0 && reg_wdata[7]);
    cover property (level_pin_a && level_pin_b);
    cover property (sleep_active && reg_wr);
endmodule // rlc_checker

bind rlc_ref_ladder_ctrl rlc_checker #(.TAPS(TAPS)) u_chk (.*);

// ===== testbench/rlc_ladder_model.sv
// far-side model: ladder tap readout and pad wire levels
`timescale 1ns/100ps
module rlc_ladder_model (
    // controls from the block
    input wire [31:0] tap_sel,
    input wire        lvl_a, lvl_b, out_a, out_b, oe_b_a, oe_b_b,
    // tap seen on the ladder, pad levels
    output reg [4:0]  tap_idx,
    output reg        tap_one,
    output wire       in_a, in_b
);
    integer i;
    // two closed switches would short the ladder, so tap_one flags exactly one
    always @* begin
        tap_idx = 5'h0;
        tap_one = 1'b0;
        for (i = 0; i < 32; i = i + 1)
            if (tap_sel[i]) begin
                tap_idx = i[4:0];
                tap_one = tap_sel == (32'h1 << i);
            end
    end
    // a level pin sits near mid rail and a plain buffer would read it high
    assign in_a = (!oe_b_a && !lvl_a) ? out_a : 1'b1;
    assign in_b = (!oe_b_b && !lvl_b) ? out_b : 1'b1;
endmodule // rlc_ladder_model

// ===== testbench/tb.sv
// self-checking bench for the reference ladder control
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    reg ref_clk = 0, rst_b = 1, reg_wr = 0, reg_rd = 0, sleep_active = 0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg [3:0] dg = 4'h0; // digital pad side: ccd, pullup, oe_b, out
    wire pad_a_dig_out = dg[0], pad_b_dig_out = dg[0], pad_a_dig_oe_b = dg[1], pad_b_dig_oe_b = dg[1];
    wire pad_a_dig_pullup_en = dg[2], pad_b_dig_pullup_en = dg[2], pad_a_dig_ccd_en = dg[3], pad_b_dig_ccd_en = dg[3];
    wire [7:0] reg_rdata;
    wire [31:0] ladder_tap_sel;
    wire ladder_power_en, high_src_supply, high_src_ext_pin, high_src_fixed_ref, low_src_ground, low_src_ext_pin;
    wire pad_a_in, pad_a_out, pad_a_oe_b, pad_a_in_en, pad_a_pullup_en, pad_a_ccd_en, level_pin_a, pad_a_rd;
    wire pad_b_in, pad_b_out, pad_b_oe_b, pad_b_in_en, pad_b_pullup_en, pad_b_ccd_en, level_pin_b, pad_b_rd;
    wire [4:0] tap_idx;
    wire tap_one;
    integer fail_count = 0, n_tests = 0, i;
    reg [7:0] q;
    reg [19:0] rows [0:9] = '{20'h0ffbd, 20'h04200, 20'h08080, 20'h08484, 20'h08888,
        20'h08c8c, 20'h08181, 20'h1ff1f, 20'h1e000, 20'h25a00}; // addr, write, readback

    rlc_ref_ladder_ctrl dut (.*);
    rlc_ladder_model u_far (.tap_sel(ladder_tap_sel), .lvl_a(level_pin_a), .lvl_b(level_pin_b),
        .out_a(pad_a_out), .out_b(pad_b_out), .oe_b_a(pad_a_oe_b), .oe_b_b(pad_b_oe_b),
        .tap_idx(tap_idx), .tap_one(tap_one), .in_a(pad_a_in), .in_b(pad_b_in));

    initial forever #2.5 ref_clk = ~ref_clk;

    // one-cycle strobes; the trailing #1 lets the edge's updates land before checks
    task wr(input [3:0] a, input [7:0] d);
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge ref_clk) reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input [3:0] a);
        @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task conclude;
        $display("checks %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    initial begin
        #100000;
        fail_count++;
        conclude;
    end

    initial begin
        rst_b <= 1'b0; // a real falling edge, so the flops clear before the first clock
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(4'h0); `CHK(q, 8'h00)
        rd(4'h1); `CHK(q, 8'h00)
        $display("reset values done");
        // rows include the reserved source code and an unmapped address
        for (i = 0; i < 10; i++) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16]); `CHK(q, rows[i][7:0])
            if (rows[i][19:16] == 4'h0) begin
                `CHK({high_src_fixed_ref, high_src_ext_pin, high_src_supply}, rows[i][7] ? 3'h1 << rows[i][3:2] : 3'h0)
                `CHK({low_src_ext_pin, low_src_ground}, rows[i][7] ? {rows[i][0], !rows[i][0]} : 2'h0)
                `CHK({ladder_power_en, level_pin_a, level_pin_b}, {rows[i][7], rows[i][5:4]})
            end
        end
        $display("register rows done");
        wr(4'h0, 8'h80);
        for (i = 0; i < 32; i++) begin
            wr(4'h1, i[7:0]);
            `CHK({tap_one, tap_idx}, {1'b1, i[4:0]})
        end
        $display("tap sweep done");
        @(posedge ref_clk) dg <= 4'hd;
        wr(4'h0, 8'h20);
        `CHK(ladder_tap_sel, 32'h0)
        `CHK({pad_a_oe_b, pad_a_in_en, pad_a_pullup_en, pad_a_ccd_en, pad_a_out, pad_a_rd}, 6'h20)
        `CHK({pad_b_oe_b, pad_b_in_en, pad_b_pullup_en, pad_b_ccd_en, pad_b_out, pad_b_rd}, 6'h1f)
        // write then read on the very next cycle
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {4'h0, 8'h10, 1'b1};
        @(posedge ref_clk) {reg_wr, reg_rd} <= 2'b01;
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, 8'h10)
        `CHK({pad_b_oe_b, pad_b_in_en, pad_b_pullup_en, pad_b_ccd_en, pad_b_out, pad_b_rd}, 6'h20)
        `CHK({pad_a_oe_b, pad_a_in_en, pad_a_pullup_en, pad_a_ccd_en, pad_a_out, pad_a_rd}, 6'h1f)
        $display("pad override done");
        @(posedge ref_clk) sleep_active <= 1'b1;
        wr(4'h0, 8'hb5);
        repeat (4) @(posedge ref_clk);
        sleep_active <= 1'b0;
        rd(4'h0); `CHK(q, 8'hb5)
        `CHK({ladder_power_en, level_pin_a, level_pin_b, high_src_ext_pin}, 4'hf)
        $display("sleep done");
        @(posedge ref_clk) rst_b <= 1'b0;
        @(posedge ref_clk) #1;
        `CHK({ladder_power_en, level_pin_a, level_pin_b, ladder_tap_sel}, 35'h0)
        @(posedge ref_clk) rst_b <= 1'b1;
        wr(4'h0, 8'h80);
        `CHK(ladder_tap_sel, 32'h1)
        $display("mid-run reset done");
        conclude;
    end
endmodule // tb
